// >>> src/scie_defines.svh
// offsets, field positions, reset values for the card irq/select registers
`ifndef SCIE_DEFINES_SVH
`define SCIE_DEFINES_SVH
`define SCIE_ADDR_SELECT 8'hab
`define SCIE_ADDR_IRQ 8'hae
`define SCIE_SEL_RESET 8'h08
`define SCIE_IER_RESET 8'h00
`define SCIE_IER_RSVD 6
`define SCIE_SEL_REPEAT 4
`define SCIE_SEL_PS_HI 3
`define SCIE_SEL_PS_LO 2
`define SCIE_SEL_ROUTE 1
`define SCIE_SEL_BANK 0
`define SCIE_REPEAT_FIVE 4'h5
`define SCIE_REPEAT_FOUR 4'h4
`endif

// >>> src/scie_pkg.sv
// types for the card irq enable and select registers
package scie_pkg;
   typedef logic [7:0] scie_byte_t;
   typedef enum logic [1:0] {
      SCIE_DIV1,
      SCIE_DIV2,
      SCIE_DIV4,
      SCIE_DIV8
   } scie_prescale_t;
endpackage : scie_pkg

// >>> src/scie_regs.sv
// card uart irq enable, identify read-clear and interface select registers
`timescale 1ns/1ps
`include "scie_defines.svh"

// Function
// - enable bit 7 lets the transmit-buffer-empty event raise the request.
// - enable bit 5 lets the card overcurrent event raise the request.
// - enable bit 2 lets the transmit-complete event raise the request.
// - enable bit 1 lets the receive-complete event raise the request.
// - enable bit 0 lets the receive parity error raise the request.
// - enable bits 4 and 3 gate card voltage error and wait timeout alike.
// - the enable register answers at aeh only while bank select is 1.
// - reset clears all enables; bit 6 is reserved and kept unchanged.
// - repeat select 0 allows five repetitions, 1 allows four.
// - prescale codes 0..3 toggle the alternate clock every 1, 2, 4, 8 cycles, dividing clk_i by 2, 4, 8, 16.
// - route bit 1 drives the alternate clock pin, 0 leaves port control.
// - select register resets to repeat 0, prescale 2, route 0, bank 0.
// - reading the identify register clears its flags by hardware.
module scie_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // special-function register bus
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   // event pulses from the card uart, bit order as the enables
   input wire logic [7:0] event_i,
   // card interface outputs
   output logic irq_o,
   output logic [3:0] repeat_limit_o,
   output logic alt_card_clock_o,
   output logic alt_clock_route_o
);

   logic [7:0] card_uart_irq_enable;
   logic [7:0] card_interface_select;
   logic [7:0] card_uart_irq_identify;
   logic [3:0] div_cnt;
   logic [3:0] next_div_cnt;
   logic bank;
   logic wr_ier;
   logic rd_iir;
   logic wr_sel;

   function automatic logic [3:0] div_len(input scie_pkg::scie_prescale_t c);
      case (c)
         scie_pkg::SCIE_DIV1: div_len = 4'h1;
         scie_pkg::SCIE_DIV2: div_len = 4'h2;
         scie_pkg::SCIE_DIV4: div_len = 4'h4;
         scie_pkg::SCIE_DIV8: div_len = 4'h8;
         default: div_len = 4'h4;
      endcase
   endfunction : div_len

   assign bank = card_interface_select[`SCIE_SEL_BANK];
   assign wr_ier = sfr_wr_i && sfr_addr_i == `SCIE_ADDR_IRQ && bank;
   assign rd_iir = sfr_rd_i && sfr_addr_i == `SCIE_ADDR_IRQ && !bank;
   assign wr_sel = sfr_wr_i && sfr_addr_i == `SCIE_ADDR_SELECT;

   // enable register
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         card_uart_irq_enable <= `SCIE_IER_RESET;
      end else if (wr_ier) begin
         card_uart_irq_enable <= sfr_wdata_i;
         card_uart_irq_enable[`SCIE_IER_RSVD] <=
            card_uart_irq_enable[`SCIE_IER_RSVD];
      end
   end

   // select register
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         card_interface_select <= `SCIE_SEL_RESET;
      end else if (wr_sel) begin
         card_interface_select <= {3'h0, sfr_wdata_i[4:0]};
      end
   end

   // identify flags, new events win over the read clear
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         card_uart_irq_identify <= 8'h00;
      end else begin
         card_uart_irq_identify <= (rd_iir ? 8'h00 : card_uart_irq_identify)
            | (event_i & 8'hbf);
      end
   end

   // read data
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sfr_rdata_o <= 8'h00;
         sfr_hit_o <= 1'b0;
      end else begin
         sfr_hit_o <= 1'b0;
         sfr_rdata_o <= 8'h00;
         if (sfr_rd_i && sfr_addr_i == `SCIE_ADDR_SELECT) begin
            sfr_rdata_o <= card_interface_select;
            sfr_hit_o <= 1'b1;
         end else if (sfr_rd_i && sfr_addr_i == `SCIE_ADDR_IRQ) begin
            sfr_rdata_o <= bank ? card_uart_irq_enable
                                : card_uart_irq_identify;
            sfr_hit_o <= 1'b1;
         end
      end
   end

   // interrupt request
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(card_uart_irq_identify & card_uart_irq_enable
                    & 8'hbf);
      end
   end

   // repetition limit
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         repeat_limit_o <= `SCIE_REPEAT_FIVE;
      end else begin
         repeat_limit_o <= card_interface_select[`SCIE_SEL_REPEAT] ?
            `SCIE_REPEAT_FOUR : `SCIE_REPEAT_FIVE;
      end
   end

   // alternate clock divider, output toggles every half period
   assign next_div_cnt = (div_cnt + 4'h1 >= div_len(scie_pkg::scie_prescale_t'(
      card_interface_select[`SCIE_SEL_PS_HI:`SCIE_SEL_PS_LO]))) ? 4'h0
      : div_cnt + 4'h1;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         div_cnt <= 4'h0;
         alt_card_clock_o <= 1'b0;
         alt_clock_route_o <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         if (next_div_cnt == 4'h0) begin
            alt_card_clock_o <= !alt_card_clock_o;
         end
         alt_clock_route_o <= card_interface_select[`SCIE_SEL_ROUTE];
      end
   end

   a_ier_reset: assert property (@(posedge clk_i) !rstn_i |=>
      card_uart_irq_enable == 8'h00) else $error("enable not cleared");
   a_sel_reset: assert property (@(posedge clk_i) !rstn_i |=>
      card_interface_select == 8'h08) else $error("select bad reset");
   a_ier_bank: assert property (@(posedge clk_i) disable iff (!rstn_i)
      sfr_wr_i && sfr_addr_i == 8'hae && !bank |=>
      $stable(card_uart_irq_enable)) else $error("enable hit bank 0");
   a_ier_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_ier |=> card_uart_irq_enable[7] == $past(sfr_wdata_i[7])
      && card_uart_irq_enable[5:0] == $past(sfr_wdata_i[5:0]))
      else $error("enable write lost");
   a_ier_rsvd: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_ier |=> $stable(card_uart_irq_enable[`SCIE_IER_RSVD]))
      else $error("reserved enable bit changed");
   a_irq_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
      card_uart_irq_enable == 8'h00 |=> !irq_o)
      else $error("irq with no enable");
   a_irq_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (card_uart_irq_identify[7] && card_uart_irq_enable[7]) |=> irq_o)
      else $error("enabled flag gave no irq");
   a_iir_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_iir && event_i == 8'h00 |=> card_uart_irq_identify == 8'h00)
      else $error("identify not cleared");
   a_set_wins: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_iir && event_i[2] |=> card_uart_irq_identify[2])
      else $error("event lost on read");
   a_rd_ident: assert property (@(posedge clk_i) disable iff (!rstn_i)
      rd_iir |=> sfr_hit_o && sfr_rdata_o == $past(card_uart_irq_identify))
      else $error("identify read wrong");
   a_rd_enable: assert property (@(posedge clk_i) disable iff (!rstn_i)
      sfr_rd_i && sfr_addr_i == `SCIE_ADDR_IRQ && bank |=> sfr_hit_o
      && sfr_rdata_o == $past(card_uart_irq_enable))
      else $error("enable read wrong");
   a_sel_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wr_sel |=> card_interface_select == {3'h0, $past(sfr_wdata_i[4:0])})
      else $error("select write lost");
   a_hit_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
      sfr_rd_i && (sfr_addr_i == `SCIE_ADDR_SELECT
      || sfr_addr_i == `SCIE_ADDR_IRQ) |=> sfr_hit_o)
      else $error("mapped read missed");
   a_unmapped: assert property (@(posedge clk_i) disable iff (!rstn_i)
      sfr_rd_i && sfr_addr_i != `SCIE_ADDR_SELECT
      && sfr_addr_i != `SCIE_ADDR_IRQ |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
      else $error("unmapped read answered");
   a_repeat_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
      card_interface_select[4] |=> repeat_limit_o == 4'h4)
      else $error("repeat limit wrong");
   a_limit_five: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !card_interface_select[`SCIE_SEL_REPEAT] |=> repeat_limit_o == 4'h5)
      else $error("repeat limit not five");
   a_div8_clk: assert property (@(posedge clk_i) disable iff (!rstn_i)
      card_interface_select[3:2] == 2'h3 && div_cnt == 4'h0 |->
      div_cnt == 4'h0 ##1 div_cnt == 4'h1)
      else $error("divider step wrong");
   a_div1_clk: assert property (@(posedge clk_i) disable iff (!rstn_i)
      card_interface_select[3:2] == 2'h0 |=> $changed(alt_card_clock_o))
      else $error("divide by one not toggling");
   a_route_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ##1 alt_clock_route_o == $past(card_interface_select[1]))
      else $error("route not followed");

   c_irq_raised: cover property (@(posedge clk_i) disable iff (!rstn_i)
      !irq_o ##1 irq_o);
   c_iir_read: cover property (@(posedge clk_i) disable iff (!rstn_i)
      rd_iir && card_uart_irq_identify != 8'h00);
   c_ier_write: cover property (@(posedge clk_i) disable iff (!rstn_i)
      wr_ier);
   c_div1: cover property (@(posedge clk_i) disable iff (!rstn_i)
      card_interface_select[3:2] == 2'h0 && alt_card_clock_o);
   c_set_wins: cover property (@(posedge clk_i) disable iff (!rstn_i)
      rd_iir && event_i != 8'h00);

endmodule : scie_regs

// >>> verif/smart_card_irq_enable_and_select_bench.sv
// self-checking bench for the card irq enable and select registers
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
   errors++; $display("Error %s exp %h got %h", n, e, s); end end
module smart_card_irq_enable_and_select_bench;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   logic sfr_rd_i = 1'b0;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] event_i = 8'h00;
   logic [7:0] sfr_rdata_o;
   logic sfr_hit_o;
   logic irq_o;
   logic [3:0] repeat_limit_o;
   logic alt_card_clock_o;
   logic alt_clock_route_o;
   int errors = 0;
   int n_compared = 0;
   logic [7:0] ier, idf, d, q;
   logic last;
   int p;
   int m_ier = 0;
   int m_sel = 8'h08;
   int m_iir = 0;
   int mexp;
   int exp_q[$];
   scie_regs scie_regs_inst (.clk_i(clk_i), .rstn_i(rstn_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .sfr_hit_o(sfr_hit_o), .event_i(event_i), .irq_o(irq_o),
      .repeat_limit_o(repeat_limit_o), .alt_card_clock_o(alt_card_clock_o),
      .alt_clock_route_o(alt_clock_route_o));
   initial begin
      forever #4 clk_i = ~clk_i;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_addr_i = a;
      sfr_wdata_i = v;
      sfr_wr_i = 1'b1;
      if (a == 8'hae && m_sel[0]) m_ier = v & 8'hbf;
      if (a == 8'hab) m_sel = v & 8'h1f;
      @(posedge clk_i);
      #1 sfr_wr_i = 1'b0;
      @(posedge clk_i);
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      sfr_addr_i = a;
      sfr_rd_i = 1'b1;
      if (a == 8'hab) exp_q.push_back(m_sel);
      else if (a == 8'hae) exp_q.push_back(m_sel[0] ? m_ier : m_iir);
      else exp_q.push_back(0);
      if (a == 8'hae && !m_sel[0]) m_iir = 0;
      @(posedge clk_i);
      #1 sfr_rd_i = 1'b0;
      v = sfr_rdata_o;
      mexp = exp_q.pop_front();
      `CHK("model rdata", mexp, v)
      `CHK("hit", (a == 8'hab || a == 8'hae), sfr_hit_o)
      @(posedge clk_i);
      #1;
   endtask : rd
   task automatic give_verdict();
      if (errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (6000) @(posedge clk_i);
      errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'hc68895cb));
      repeat (16) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      rd(8'hab, q);
      `CHK("select", 8'h08, q)
      `CHK("limit", 4'h5, repeat_limit_o)
      rd(8'hae, q);
      `CHK("identify", 8'h00, q)
      rd(8'h5a, q);
      `CHK("unmapped", 8'h00, q)
      wr(8'hae, 8'hff);
      wr(8'hab, 8'h01);
      rd(8'hae, q);
      `CHK("enable", 8'h00, q)
      for (int n = 0; n < 16; n++) begin
         d = 8'($urandom);
         d[n % 8] = n[3];
         ier = d & 8'hbf;
         idf = 8'h01 << (n % 8);
         wr(8'hab, 8'h09);
         wr(8'hae, d);
         event_i = idf;
         m_iir = m_iir | (idf & 8'hbf);
         @(posedge clk_i);
         #1 event_i = 8'h00;
         idf = idf & 8'hbf;
         @(posedge clk_i);
         #1;
         `CHK("irq", |(idf & ier), irq_o)
         `CHK("model irq", |(m_iir & m_ier), irq_o)
         rd(8'hae, q);
         `CHK("enable", ier, q)
         wr(8'hab, 8'h08);
         rd(8'hae, q);
         `CHK("identify", idf, q)
         `CHK("irq", 1'b0, irq_o)
         `CHK("model irq", |(m_iir & m_ier), irq_o)
      end
      event_i = 8'h44;
      rd(8'hae, q);
      event_i = 8'h00;
      m_iir = m_iir | 8'h04;
      `CHK("identify", 8'h00, q)
      rd(8'hae, q);
      `CHK("set wins", 8'h04, q)
      for (int c = 0; c < 8; c++) begin
         d = {3'($urandom), c[2], c[1:0], 1'($urandom), 1'b0};
         wr(8'hab, d);
         rd(8'hab, q);
         `CHK("select", d & 8'h1f, q)
         `CHK("limit", c[2] ? 4'h4 : 4'h5, repeat_limit_o)
         `CHK("route", d[1], alt_clock_route_o)
         p = -1;
         last = alt_card_clock_o;
         for (int i = 0; i < 40; i++) begin
            @(posedge clk_i);
            #1;
            if (alt_card_clock_o !== last) begin
               if (p >= 0) `CHK("half", 1 << c[1:0], i - p)
               p = i;
               last = alt_card_clock_o;
            end
         end
         `CHK("toggled", 1'b1, p >= 0)
      end
      wr(8'hab, 8'h17);
      wr(8'hae, 8'hbf);
      rstn_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      m_ier = 0;
      m_sel = 8'h08;
      m_iir = 0;
      rd(8'hab, q);
      `CHK("select", 8'h08, q)
      `CHK("limit", 4'h5, repeat_limit_o)
      `CHK("route", 1'b0, alt_clock_route_o)
      `CHK("irq", 1'b0, irq_o)
      wr(8'hab, 8'h01);
      rd(8'hae, q);
      `CHK("enable", 8'h00, q)
      give_verdict();
   end
endmodule : smart_card_irq_enable_and_select_bench
